// >>> pcs_ctl_pkg.sv
// Package: register map, field positions, reset values, timing and path types
package pcs_ctl_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CODING_SUBLAYER_CONFIG = 6'h17;
    localparam logic [5:0] IDX_LOOPBACK_BYPASS_CONTROL = 6'h18;
    localparam logic [5:0] IDX_JABBER_CONFIG = 6'h19;
    localparam logic [5:0] IDX_TEN_MEG_CONFIG_STATUS = 6'h1B;
    localparam logic [5:0] IDX_PATH_STATUS = 6'h1C;

    // Field positions
    localparam int BIT_LINE_CODING_EN = 15;
    localparam int BIT_RELAY_STATION = 12;
    localparam int BIT_CODE_GROUP_BYPASS = 14;
    localparam int BIT_SCRAMBLER_BYPASS = 13;
    localparam int BIT_FULL_CHANNEL_BYPASS = 12;
    localparam int BIT_JABBER_OVERRIDE = 11;
    localparam int BIT_TEN_MEG_SERIAL = 9;
    localparam int BIT_STAT_CRS = 0;
    localparam int BIT_STAT_JABBER = 1;
    localparam int BIT_STAT_CIM = 2;
    localparam int BIT_STAT_MODE_LO = 4;
    localparam int BIT_STAT_FIFO_EMPTY = 8;

    // Reset values of bits not taken from straps
    localparam logic RST_LINE_CODING_EN = 1'b1;
    localparam logic RST_JABBER_OVERRIDE = 1'b0;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int JABBER_TIME_US = 722;
    localparam int JABBER_CYCLES = (JABBER_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int JABBER_CNT_W = 14;

    // Buffering
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [1:0] {
        MII_NIBBLE_100  = 2'b00,
        MII_CODE_GROUP  = 2'b01,
        MII_NIBBLE_10   = 2'b10,
        MII_SERIAL_10   = 2'b11
    } mii_mode_t;

    typedef enum logic [1:0] {
        MII_CLK_25M  = 2'b00,
        MII_CLK_2M5  = 2'b01,
        MII_CLK_10M  = 2'b10
    } mii_clk_t;

    typedef struct packed {
        logic [4:0] sym;
        logic       err;
    } sym_word_t;

    typedef struct packed {
        logic      code_group_bypass;
        logic      scrambler_bypass;
        logic      line_coding_en;
        logic      carrier_integrity_check;
        mii_mode_t mode;
        mii_clk_t  clk_rate;
    } path_ctl_t;

endpackage

// >>> phy_coding_path_control.sv
// Coding sublayer configuration, carrier sense control and transmit symbol buffer
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Transmit symbol FIFO; ready and valid are registered from the next count

module pcs_sym_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output var  logic             in_ready_o,
    output var  logic [WIDTH-1:0] out_data_o,
    output var  logic             out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign push = in_valid_i & in_ready_o;
    assign pop  = out_valid_o & out_ready_i;
    assign out_data_o = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + (AW+1)'(1);
        end else if (pop && !push) begin
            next_count = count - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count       <= '0;
            in_ready_o  <= 1'b0;
            out_valid_o <= 1'b0;
        end else begin
            count       <= next_count;
            in_ready_o  <= (next_count != (AW+1)'(DEPTH));
            out_valid_o <= (next_count != '0);
        end
    end

endmodule

////////////////////////////////////////////////////////////////////////////////
// Top level

// Summary of operation
// R1: Code-group bypass skips transmit encoder and receive decoder; default from strap.
// R2: Scrambler bypass skips transmit scrambler and receive descrambler; default from strap.
// R3: Line transition coding enable resets to one; clearing bypasses NRZI both ways.
// R4: Software keeps NRZI coding enabled in normal 100 Mb/s use; test only.
// R5: Full channel bypass skips every 100 Mb/s coding stage; default from strap.
// R6: Relay station mode: carrier sense on receive only; otherwise receive or transmit.
// R7: At 10 Mb/s relay station mode changes carrier sense behaviour only.
// R8: At 100 Mb/s relay station mode enables carrier integrity check; node mode off.
// R9: At 100 Mb/s relay station mode holds carrier sense through long jabber.
// R10: A separate configuration bit overrides holding carrier sense during jabber.
// R11: At 100 Mb/s MII runs nibble clocking at 25 MHz regardless of bypass.
// R12: With code-group or full bypass, fifth bit travels on TX_ER and RX_ER.
// R13: In 10 Mb/s nibble mode clocks run 2.5 MHz; bypasses have no effect.
// R14: 10 Mb/s serial mode uses TXD[0] and RXD[0] at 10 MHz only.
// R15: Serial mode keeps CRS, COL, error and valid signals working as nibble mode.
// R16: Ten meg serial select bit chooses serial mode; default from serial strap.
// R17: Straps sampled during reset load the register bits at release.
// R18: Node mode or override drops carrier sense when jabber time limit passes.
module phy_coding_path_control #(
    parameter int JABBER_CYCLES = pcs_ctl_pkg::JABBER_CYCLES
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output var  logic [31:0]            wb_dat_o,
    output var  logic                   wb_ack_o,
    input  wire logic                   code_group_bypass_strap_i,
    input  wire logic                   scrambler_bypass_strap_i,
    input  wire logic                   full_channel_bypass_strap_i,
    input  wire logic                   relay_station_strap_i,
    input  wire logic                   serial_mode_strap_i,
    input  wire logic                   speed_100_i,
    input  wire logic                   rx_active_i,
    input  wire logic                   tx_active_i,
    input  wire logic [3:0]             txd_i,
    input  wire logic                   tx_er_i,
    input  wire logic                   tx_en_i,
    output var  logic                   tx_ready_o,
    output var  pcs_ctl_pkg::sym_word_t sym_o,
    output var  logic                   sym_valid_o,
    input  wire logic                   sym_ready_i,
    input  wire logic [4:0]             rx_sym_i,
    input  wire logic                   rx_err_i,
    input  wire logic                   rx_dv_i,
    output var  logic [3:0]             rxd_o,
    output var  logic                   rx_er_o,
    output var  logic                   rx_dv_o,
    output var  logic                   crs_o,
    output var  pcs_ctl_pkg::path_ctl_t path_o
);
    localparam int CW = pcs_ctl_pkg::JABBER_CNT_W;

    logic                   code_group_bypass;
    logic                   scrambler_bypass;
    logic                   full_channel_bypass;
    logic                   line_coding_en;
    logic                   relay_station_mode;
    logic                   jabber_override;
    logic                   ten_meg_serial_select;
    logic [CW-1:0]          jabber_cnt;
    logic                   jabber_expired;
    logic                   wb_req;
    logic                   wb_wr_lo;
    logic                   wb_wr_hi;
    logic [5:0]             wb_idx;
    logic [15:0]            next_rdata;
    pcs_ctl_pkg::mii_mode_t next_mode;
    pcs_ctl_pkg::sym_word_t tx_word;
    pcs_ctl_pkg::sym_word_t fifo_out;
    logic                   fifo_valid;
    logic                   fifo_pop;
    logic                   fifo_empty_seen;
    logic                   hold_in_jabber;

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait state, ack held for one cycle

    assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_idx   = wb_adr_i[7:2];
    assign wb_wr_lo = wb_req & wb_we_i & wb_sel_i[0];
    assign wb_wr_hi = wb_req & wb_we_i & wb_sel_i[1];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                wb_dat_o <= {16'h0000, next_rdata};
            end
        end
    end

    always_comb begin
        next_rdata = 16'h0000;
        case (wb_idx)
            pcs_ctl_pkg::IDX_CODING_SUBLAYER_CONFIG: begin
                next_rdata[pcs_ctl_pkg::BIT_LINE_CODING_EN] = line_coding_en;
                next_rdata[pcs_ctl_pkg::BIT_RELAY_STATION]  = relay_station_mode;
            end
            pcs_ctl_pkg::IDX_LOOPBACK_BYPASS_CONTROL: begin
                next_rdata[pcs_ctl_pkg::BIT_CODE_GROUP_BYPASS]   = code_group_bypass;
                next_rdata[pcs_ctl_pkg::BIT_SCRAMBLER_BYPASS]    = scrambler_bypass;
                next_rdata[pcs_ctl_pkg::BIT_FULL_CHANNEL_BYPASS] = full_channel_bypass;
            end
            pcs_ctl_pkg::IDX_JABBER_CONFIG: begin
                next_rdata[pcs_ctl_pkg::BIT_JABBER_OVERRIDE] = jabber_override;
            end
            pcs_ctl_pkg::IDX_TEN_MEG_CONFIG_STATUS: begin
                next_rdata[pcs_ctl_pkg::BIT_TEN_MEG_SERIAL] = ten_meg_serial_select;
            end
            pcs_ctl_pkg::IDX_PATH_STATUS: begin
                next_rdata[pcs_ctl_pkg::BIT_STAT_CRS]    = crs_o;
                next_rdata[pcs_ctl_pkg::BIT_STAT_JABBER] = jabber_expired;
                next_rdata[pcs_ctl_pkg::BIT_STAT_CIM]    = path_o.carrier_integrity_check;
                next_rdata[pcs_ctl_pkg::BIT_STAT_MODE_LO +: 2] = path_o.mode;
                next_rdata[pcs_ctl_pkg::BIT_STAT_FIFO_EMPTY]   = fifo_empty_seen;
            end
            default: begin
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Straps follow the pins during reset; the value at release is kept

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code_group_bypass   <= code_group_bypass_strap_i;   // see R1 R17
            scrambler_bypass    <= scrambler_bypass_strap_i;    // see R2 R17
            full_channel_bypass <= full_channel_bypass_strap_i; // see R5 R17
        end else if (wb_wr_hi && wb_idx == pcs_ctl_pkg::IDX_LOOPBACK_BYPASS_CONTROL) begin
            code_group_bypass   <= wb_dat_i[pcs_ctl_pkg::BIT_CODE_GROUP_BYPASS];
            scrambler_bypass    <= wb_dat_i[pcs_ctl_pkg::BIT_SCRAMBLER_BYPASS];
            full_channel_bypass <= wb_dat_i[pcs_ctl_pkg::BIT_FULL_CHANNEL_BYPASS];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_coding_en     <= pcs_ctl_pkg::RST_LINE_CODING_EN; // see R3
            relay_station_mode <= relay_station_strap_i;           // see R6 R17
        end else if (wb_wr_hi && wb_idx == pcs_ctl_pkg::IDX_CODING_SUBLAYER_CONFIG) begin
            line_coding_en     <= wb_dat_i[pcs_ctl_pkg::BIT_LINE_CODING_EN];
            relay_station_mode <= wb_dat_i[pcs_ctl_pkg::BIT_RELAY_STATION];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            jabber_override <= pcs_ctl_pkg::RST_JABBER_OVERRIDE;
        end else if (wb_wr_hi && wb_idx == pcs_ctl_pkg::IDX_JABBER_CONFIG) begin
            jabber_override <= wb_dat_i[pcs_ctl_pkg::BIT_JABBER_OVERRIDE]; // see R10
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ten_meg_serial_select <= serial_mode_strap_i; // see R16 R17
        end else if (wb_wr_hi && wb_idx == pcs_ctl_pkg::IDX_TEN_MEG_CONFIG_STATUS) begin
            ten_meg_serial_select <= wb_dat_i[pcs_ctl_pkg::BIT_TEN_MEG_SERIAL];
        end
    end

    // Low byte only clears the sticky empty flag; set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fifo_empty_seen <= 1'b0;
        end else if (!fifo_valid) begin
            fifo_empty_seen <= 1'b1;
        end else if (wb_wr_lo && wb_idx == pcs_ctl_pkg::IDX_PATH_STATUS
                     && wb_dat_i[pcs_ctl_pkg::BIT_STAT_FIFO_EMPTY - 8 + 8 - 8]) begin
            fifo_empty_seen <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Path control: bypasses only matter at 100 Mb/s

    always_comb begin
        if (speed_100_i) begin
            next_mode = (code_group_bypass || full_channel_bypass)
                      ? pcs_ctl_pkg::MII_CODE_GROUP : pcs_ctl_pkg::MII_NIBBLE_100; // see R12
        end else if (ten_meg_serial_select) begin
            next_mode = pcs_ctl_pkg::MII_SERIAL_10;                              // see R16
        end else begin
            next_mode = pcs_ctl_pkg::MII_NIBBLE_10;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            path_o <= '0;
        end else begin
            path_o.code_group_bypass <= speed_100_i
                                      & (code_group_bypass | full_channel_bypass); // see R1 R5 R13
            path_o.scrambler_bypass  <= speed_100_i
                                      & (scrambler_bypass | full_channel_bypass);  // see R2 R5 R13
            // NRZI stage idles below 100 Mb/s; enable reads set
            path_o.line_coding_en    <= ~speed_100_i
                                      | (line_coding_en & ~full_channel_bypass);   // see R3 R5
            path_o.carrier_integrity_check <= speed_100_i & relay_station_mode;    // see R8
            path_o.mode <= next_mode;
            case (next_mode)
                pcs_ctl_pkg::MII_NIBBLE_100, pcs_ctl_pkg::MII_CODE_GROUP: begin
                    path_o.clk_rate <= pcs_ctl_pkg::MII_CLK_25M; // see R11
                end
                pcs_ctl_pkg::MII_SERIAL_10: begin
                    path_o.clk_rate <= pcs_ctl_pkg::MII_CLK_10M; // see R14
                end
                default: begin
                    path_o.clk_rate <= pcs_ctl_pkg::MII_CLK_2M5; // see R13
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Carrier sense and jabber timing

    // Counter saturates so a very long reception cannot wrap and re-arm
    always_ff @(posedge clk_i) begin
        if (rst_i || !rx_active_i) begin
            jabber_cnt     <= '0;
            jabber_expired <= 1'b0;
        end else begin
            if (jabber_cnt != CW'(JABBER_CYCLES)) begin
                jabber_cnt <= jabber_cnt + CW'(1);
            end
            jabber_expired <= (jabber_cnt >= CW'(JABBER_CYCLES - 1));
        end
    end

    // Speed, relay mode and override gate the hold; at 10 Mb/s the relay mode touches CRS alone
    assign hold_in_jabber = speed_100_i & relay_station_mode & ~jabber_override; // see R9 R10 R7

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crs_o <= 1'b0;
        end else begin
            crs_o <= (rx_active_i & ~(jabber_expired & ~hold_in_jabber)) // see R9 R18
                   | (~relay_station_mode & tx_active_i);                // see R6 R7
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive formatting; DV and error keep nibble behaviour in serial mode

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxd_o   <= 4'h0;
            rx_er_o <= 1'b0;
            rx_dv_o <= 1'b0;
        end else begin
            rx_dv_o <= rx_dv_i; // see R15
            case (path_o.mode)
                pcs_ctl_pkg::MII_CODE_GROUP: begin
                    rxd_o   <= rx_sym_i[3:0];
                    rx_er_o <= rx_sym_i[4]; // see R12
                end
                pcs_ctl_pkg::MII_SERIAL_10: begin
                    rxd_o   <= {3'h0, rx_sym_i[0]}; // see R14
                    rx_er_o <= rx_err_i;            // see R15
                end
                default: begin
                    rxd_o   <= rx_sym_i[3:0];
                    rx_er_o <= rx_err_i;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit formatting and buffering

    always_comb begin
        tx_word.sym = {1'b0, txd_i};
        tx_word.err = tx_er_i;
        case (path_o.mode)
            pcs_ctl_pkg::MII_CODE_GROUP: begin
                tx_word.sym = {tx_er_i, txd_i}; // see R12
                tx_word.err = 1'b0;
            end
            pcs_ctl_pkg::MII_SERIAL_10: begin
                tx_word.sym = {4'h0, txd_i[0]}; // see R14
                tx_word.err = tx_er_i;          // see R15
            end
            default: begin
            end
        endcase
    end

    pcs_sym_fifo #(
        .WIDTH ($bits(pcs_ctl_pkg::sym_word_t)),
        .DEPTH (pcs_ctl_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_data_i   (tx_word),
        .in_valid_i  (tx_en_i),
        .in_ready_o  (tx_ready_o),
        .out_data_o  (fifo_out),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop)
    );

    assign fifo_pop = fifo_valid & (~sym_valid_o | sym_ready_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sym_valid_o <= 1'b0;
            sym_o       <= '0;
        end else if (fifo_pop) begin
            sym_valid_o <= 1'b1;
            sym_o       <= fifo_out;
        end else if (sym_ready_i) begin
            sym_valid_o <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// >>> phy_coding_path_control_asserts.sv
// Checker for bus, carrier, mode and symbol rules
`timescale 1ns/10ps
`default_nettype none
module phy_coding_path_control_asserts (
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire logic                   wb_cyc_i,
    input wire logic                   wb_stb_i,
    input wire logic                   wb_ack_o,
    input wire logic                   speed_100_i,
    input wire logic                   rx_active_i,
    input wire logic                   tx_active_i,
    input wire logic [4:0]             rx_sym_i,
    input wire logic                   rx_err_i,
    input wire logic [3:0]             rxd_o,
    input wire logic                   rx_er_o,
    input wire logic                   crs_o,
    input wire pcs_ctl_pkg::sym_word_t sym_o,
    input wire logic                   sym_valid_o,
    input wire logic                   sym_ready_i,
    input wire pcs_ctl_pkg::path_ctl_t path_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    crs_relay_a: assert property (
        speed_100_i && path_o.carrier_integrity_check && tx_active_i && !rx_active_i
        ##1 $stable(path_o) |-> !crs_o) else $error("relay crs on tx");
    crs_node_a: assert property (
        speed_100_i && !path_o.carrier_integrity_check && tx_active_i
        ##1 $stable(path_o) |-> crs_o) else $error("node crs missing");
    crs_idle_a: assert property (!rx_active_i && !tx_active_i |=> !crs_o)
        else $error("crs while idle");
    slow_path_a: assert property (!speed_100_i [*2] |->
        !path_o.carrier_integrity_check && !path_o.code_group_bypass
        && !path_o.scrambler_bypass && path_o.line_coding_en)
        else $error("bypass at low speed");
    clk_100_a: assert property (speed_100_i [*2] |->
        path_o.clk_rate == pcs_ctl_pkg::MII_CLK_25M) else $error("fast clock wrong");
    clk_10_a: assert property (!speed_100_i [*2] |-> path_o.clk_rate ==
        (path_o.mode == pcs_ctl_pkg::MII_SERIAL_10 ? pcs_ctl_pkg::MII_CLK_10M
        : pcs_ctl_pkg::MII_CLK_2M5)) else $error("slow clock wrong");
    rx_fifth_a: assert property (path_o.mode == pcs_ctl_pkg::MII_CODE_GROUP
        ##1 $stable(path_o) |-> {rx_er_o, rxd_o} == $past(rx_sym_i))
        else $error("fifth bit wrong");
    rx_serial_a: assert property (path_o.mode == pcs_ctl_pkg::MII_SERIAL_10
        ##1 $stable(path_o) |-> rxd_o == {3'b000, $past(rx_sym_i[0])}
        && rx_er_o == $past(rx_err_i)) else $error("serial rx wrong");
    sym_hold_a: assert property (sym_valid_o && !sym_ready_i |=> sym_valid_o && $stable(sym_o))
        else $error("symbol not held");

    cover property (sym_valid_o && sym_ready_i);
    cover property (speed_100_i && path_o.carrier_integrity_check && rx_active_i && crs_o);
    cover property (path_o.mode == pcs_ctl_pkg::MII_SERIAL_10);
endmodule

bind phy_coding_path_control phy_coding_path_control_asserts u_chk (.*);
`default_nettype wire

// >>> pcs_sym_sink.sv
// Symbol sink standing for the coding stages beyond the transmit buffer
`timescale 1ns/10ps
`default_nettype none
module pcs_sym_sink (
    input  wire logic                   clk_i,
    input  wire logic                   stall_i,
    input  wire logic                   slow_i,
    input  wire pcs_ctl_pkg::sym_word_t sym_i,
    input  wire logic                   valid_i,
    output var  logic                   ready_o
);
    pcs_ctl_pkg::sym_word_t got[$];
    initial ready_o = 1'b0;
    // Slow mode halves ready so held words get exercised
    always @(posedge clk_i) begin
        if (valid_i && ready_o)
            got.push_back(sym_i);
        ready_o <= !stall_i && !(slow_i && ready_o);
    end
endmodule
`default_nettype wire

// >>> phy_coding_path_control_tb_top.sv
// Self-checking bench for the coding path control block
`timescale 1ns/10ps
`default_nettype none
module phy_coding_path_control_tb_top;
    localparam int JAB = 20;
    logic        clk_i = 1'b0, rst_i = 1'b1, req = 1'b0, wb_we_i = 1'b0, stall = 1'b1;
    logic        slow = 1'b0, speed_100_i = 1'b1, rx_active_i = 1'b0, tx_active_i = 1'b0;
    logic        tx_er_i = 1'b0, tx_en_i = 1'b0, rx_err_i = 1'b0, rx_dv_i = 1'b0;
    logic        wb_ack_o, tx_ready_o, sym_valid_o, sym_ready_i, rx_er_o, rx_dv_o, crs_o;
    logic [3:0]  wb_sel_i = 4'h0, txd_i = 4'h0, rxd_o;
    logic [4:0]  straps = 5'h00, rx_sym_i = 5'h00;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    pcs_ctl_pkg::sym_word_t sym_o;
    pcs_ctl_pkg::path_ctl_t path_o;
    int          fails = 0, comparisons = 0, cycles = 0;

    phy_coding_path_control #(.JABBER_CYCLES(JAB)) u_phy_coding_path_control (.*,
        .wb_cyc_i(req), .wb_stb_i(req), .code_group_bypass_strap_i(straps[4]),
        .scrambler_bypass_strap_i(straps[3]), .full_channel_bypass_strap_i(straps[2]),
        .relay_station_strap_i(straps[1]), .serial_mode_strap_i(straps[0]));
    pcs_sym_sink u_pcs_sym_sink (.clk_i, .stall_i(stall), .slow_i(slow), .sym_i(sym_o),
        .valid_i(sym_valid_o), .ready_o(sym_ready_i));

    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // No latency assumed; the timeout ends a hang
    task automatic wb(input logic we, input logic [3:0] sel, input logic [7:0] adr,
                      input logic [31:0] dat);
        @(posedge clk_i);
        req <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sel;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        req <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, 4'hF, adr, 32'h0);
        chk(rd, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Straps flip after release; only the held value may show
    task automatic t_straps(input logic [4:0] s, input logic [31:0] e17, e18, e1b);
        @(posedge clk_i);
        speed_100_i <= 1'b1;
        straps <= s;
        rst_i <= 1'b1;
        tick(12);
        rst_i <= 1'b0;
        straps <= ~s;
        rdchk(8'h5C, e17);
        rdchk(8'h60, e18);
        rdchk(8'h6C, e1b);
        rdchk(8'h64, 32'h0);
        rdchk(8'h00, 32'h0);
        wb(1'b1, 4'h1, 8'h60, 32'hFFFF);
        rdchk(8'h60, e18);
        $display("%0t straps test done", $time);
    endtask
    task automatic t_path;
        tick(2);
        chk(path_o, 8'hF4);
        rx_sym_i <= 5'h1A;
        rx_dv_i <= 1'b1;
        tick(2);
        chk({rx_er_o, rxd_o}, 5'h1A);
        wb(1'b1, 4'h2, 8'h5C, 32'h1000);
        tick(2);
        chk(path_o, 8'hD4);
        wb(1'b1, 4'h2, 8'h5C, 32'h9000);
        speed_100_i <= 1'b0;
        rx_sym_i <= 5'h13;
        rx_err_i <= 1'b1;
        tick(3);
        chk(path_o, 8'h2E);
        chk({rx_dv_o, rx_er_o, rxd_o}, 6'h31);
        wb(1'b1, 4'h2, 8'h6C, 32'h0);
        tick(2);
        chk(path_o, 8'h29);
        speed_100_i <= 1'b1;
        rx_dv_i <= 1'b0;
        tick(2);
        $display("%0t path test done", $time);
    endtask
    task automatic t_stream;
        int n;
        n = 0;
        repeat (24) begin
            @(posedge clk_i);
            if (tx_en_i && tx_ready_o)
                n++;
            tx_en_i <= 1'b1;
            txd_i <= n[3:0];
            tx_er_i <= ~n[0];
        end
        tick(1);
        tx_en_i <= 1'b0;
        // The output register holds one word beyond the buffer
        chk(n, pcs_ctl_pkg::FIFO_DEPTH + 1);
        stall <= 1'b0;
        slow <= 1'b1;
        for (int i = 0; i < 100 && u_pcs_sym_sink.got.size() < n; i++)
            tick(1);
        chk(u_pcs_sym_sink.got.size(), n);
        for (int i = 0; i < n; i++)
            chk(u_pcs_sym_sink.got[i], {~i[0], i[3:0], 1'b0});
        $display("%0t stream test done", $time);
    endtask
    task automatic t_crs(input logic spd, input logic [31:0] r17, r19, input logic txe, jabe);
        wb(1'b1, 4'h2, 8'h5C, r17);
        wb(1'b1, 4'h2, 8'h64, r19);
        speed_100_i <= spd;
        tx_active_i <= 1'b1;
        tick(3);
        chk(crs_o, txe);
        tx_active_i <= 1'b0;
        rx_active_i <= 1'b1;
        tick(3);
        chk(crs_o, 1'b1);
        tick(JAB + 2);
        chk(crs_o, jabe);
        rx_active_i <= 1'b0;
        tick(2);
        chk(crs_o, 1'b0);
        $display("%0t carrier test done", $time);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("%0t comparisons %0d fails %0d", $time, comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        t_straps(5'b11011, 32'h9000, 32'h6000, 32'h0200);
        t_path();
        t_stream();
        t_crs(1'b1, 32'h9000, 32'h0, 1'b0, 1'b1);
        t_crs(1'b1, 32'h9000, 32'h0800, 1'b0, 1'b0);
        t_crs(1'b1, 32'h8000, 32'h0, 1'b1, 1'b0);
        t_crs(1'b0, 32'h9000, 32'h0, 1'b0, 1'b0);
        t_straps(5'b00100, 32'h8000, 32'h1000, 32'h0);
        chk(path_o.mode, pcs_ctl_pkg::MII_CODE_GROUP);
        chk(path_o.line_coding_en, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
